/* File: core/smsq_core.sv */
// Serial peripheral controller, master and slave, with its quirks kept
`timescale 1ns/10ps
`include "smsq_defs.svh"
module smsq_core import smsq_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic master_select_i,
	input wire logic enable_i,
	input wire logic disable_i,
	input wire logic soft_reset_i,
	input wire logic fixed_mode_i,
	input wire logic dma_feed_i,
	input wire logic [1:0] cs_index_i,
	input wire logic [31:0] serial_clock_divider_i,
	input wire logic [15:0] word_bits_i,
	input wire logic [3:0] cs_hold_after_transfer_i,
	input wire logic [3:0] clock_polarity_i,
	input wire logic [3:0] clock_phase_inverted_i,
	input wire logic tx_valid_i,
	input wire logic [24:0] tx_data_i,
	output logic tx_ready_o,
	output logic transmit_drained_o,
	output logic enabled_o,
	output logic dma_halfword_o,
	output logic rx_valid_o,
	output logic [15:0] rx_data_o,
	input wire logic rx_ready_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_o,
	input wire logic serial_clock_pin_i,
	output logic mosi_o,
	output logic mosi_oe_o,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic miso_i,
	output logic [3:0] cs_n_o,
	input wire logic slave_select_n_i
);
	// ************************************************************
	// Configuration decode
	// ************************************************************
	logic [7:0] div [4];
	logic [4:0] nbits_of [4];
	logic [3:0] fast_map;
	genvar g;
	generate
		for (g = 0; g < `SMSQ_NUM_CS; g++) begin : g_cfg
			assign div[g] = serial_clock_divider_i[g*8 +: 8];
			// R15 length decode
			assign nbits_of[g] = `SMSQ_BASE_BITS + {1'b0, word_bits_i[g*4 +: 4]};
			assign fast_map[g] = (div[g] == `SMSQ_FAST_DIV);
		end
	endgenerate

	smsq_state_e state;
	logic enabled, hold_valid, stuck, marker_last, cs_active, last_fast, done;
	logic [24:0] hold_word;
	logic [1:0] cs_cur, sel;
	logic [7:0] hcnt, div_cur;
	logic [5:0] ecnt, etotal;
	logic [4:0] nbits;
	logic cpol, clock_phase_inverted, sck;
	smsq_word_t sh;
	logic [1:0] rx_cnt;
	logic push;
	smsq_word_t push_data;
	logic start, r1_hit, drained, tick, samp_edge, slv_load;

	// Fixed mode uses the select port, variable mode the word's select field
	assign sel = fixed_mode_i ? cs_index_i : hold_word[`SMSQ_PCS_LSB +: 2];
	assign drained = (state == SMSQ_IDLE) && !hold_valid;
	assign start = enabled && master_select_i && hold_valid && (state == SMSQ_IDLE)
		&& (rx_cnt < 2'(`SMSQ_RX_DEPTH));
	// R1 held select, fast divider, same slave after an idle gap
	assign r1_hit = cs_hold_after_transfer_i[sel] && fast_map[sel] && cs_active
		&& (cs_cur == sel) && !stuck;
	assign tick = (state == SMSQ_SHIFT) && (hcnt >= div_cur - 8'h01 || div_cur == 8'h00);
	assign done = tick && (ecnt == etotal - 6'h01);
	assign samp_edge = (ecnt[0] == ~clock_phase_inverted) && (ecnt < {nbits, 1'b0});

	// ************************************************************
	// Enable and transmit holding register
	// ************************************************************
	// R9 disable only takes effect in master operation
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) enabled <= 1'b0;
		else if (soft_reset_i) enabled <= 1'b0;
		else if (enable_i) enabled <= 1'b1;
		else if (disable_i && master_select_i) enabled <= 1'b0;
	end
	assign enabled_o = enabled;

	// R1 a stuck load keeps the word valid, so it goes out twice
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_valid <= 1'b0;
			hold_word <= 25'h0000000;
			stuck <= 1'b0;
			marker_last <= 1'b0;
		end else if (soft_reset_i) begin
			hold_valid <= 1'b0;
			stuck <= 1'b0;
			marker_last <= 1'b0;
		end else begin
			if (start || (slv_load && hold_valid)) begin
				hold_valid <= r1_hit && start;
				stuck <= r1_hit && start;
			end else if (tx_valid_i && tx_ready_o) begin
				hold_valid <= 1'b1;
				hold_word <= tx_data_i;
				marker_last <= tx_data_i[`SMSQ_MARKER_BIT];
			end
		end
	end
	assign tx_ready_o = !hold_valid && !stuck;
	assign transmit_drained_o = drained;

	// R5 fixed mode DMA size follows select zero; R15 above 8 is halfword
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) dma_halfword_o <= 1'b0;
		else dma_halfword_o <= fixed_mode_i ? (nbits_of[0] > `SMSQ_BASE_BITS)
			: (nbits_of[sel] > `SMSQ_BASE_BITS);
	end

	// ************************************************************
	// Master shifter and serial clock
	// ************************************************************
	// R7 R8 R11 R12 extra pulse chosen at start
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= SMSQ_IDLE;
			hcnt <= 8'h00;
			ecnt <= 6'h00;
			etotal <= 6'h00;
			div_cur <= 8'h00;
			nbits <= `SMSQ_BASE_BITS;
			cpol <= 1'b0;
			clock_phase_inverted <= 1'b0;
			last_fast <= 1'b1;
			sh <= 16'h0000;
		end else if (soft_reset_i) begin
			state <= SMSQ_IDLE;
		end else if (start) begin
			state <= SMSQ_SHIFT;
			hcnt <= 8'h00;
			ecnt <= 6'h00;
			div_cur <= div[sel];
			nbits <= nbits_of[sel];
			cpol <= clock_polarity_i[sel];
			clock_phase_inverted <= clock_phase_inverted_i[sel];
			last_fast <= fast_map[sel];
			sh <= hold_word[15:0] << (5'h10 - nbits_of[sel]);
			etotal <= {nbits_of[sel], 1'b0} + ((fast_map[sel] && nbits_of[sel][0])
				|| (clock_polarity_i[sel] && !clock_phase_inverted_i[sel]
				&& fast_map[sel] && !last_fast && !(&fast_map)) ? 6'h02 : 6'h00);
		end else if (state == SMSQ_SHIFT) begin
			hcnt <= tick ? 8'h00 : hcnt + 8'h01;
			if (tick) begin
				ecnt <= ecnt + 6'h01;
				if (samp_edge) sh <= {sh[14:0], miso_i};
				if (done) state <= SMSQ_IDLE;
			end
		end
	end

	// R3 idle clock follows the selected polarity, even before a transfer
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) sck <= 1'b0;
		else if (state == SMSQ_IDLE) sck <= clock_polarity_i[sel];
		else if (tick) sck <= ~sck;
	end
	assign serial_clock_pin_o = sck;
	assign serial_clock_pin_oe_o = master_select_i && enabled;

	// Data changes on the edge opposite to sampling
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) mosi_o <= 1'b0;
		else if (start) mosi_o <= hold_word[5'(nbits_of[sel] - 5'h01)];
		else if (tick && !samp_edge && ecnt < {nbits, 1'b0}) mosi_o <= sh[15];
	end
	assign mosi_oe_o = master_select_i && enabled;

	// R2 a set marker releases a held select once drained
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cs_active <= 1'b0;
			cs_cur <= 2'h0;
		end else if (soft_reset_i) begin
			cs_active <= 1'b0;
		end else if (start) begin
			cs_active <= 1'b1;
			cs_cur <= sel;
		end else if (done && !cs_hold_after_transfer_i[cs_cur]) begin
			cs_active <= 1'b0;
		end else if (drained && cs_active && marker_last) begin
			cs_active <= 1'b0;
		end
	end
	always_comb begin
		cs_n_o = 4'hF;
		if (cs_active && master_select_i) cs_n_o[cs_cur] = 1'b0;
	end

	// ************************************************************
	// Slave path, pins through three stages
	// ************************************************************
	logic [2:0] s_sck, s_ss, s_mo;
	logic f_sck, f_ss, f_mo, f_sck_d;
	logic [4:0] s_bits;
	smsq_word_t s_sh;
	// Filtered levels move only when the second and third stage agree
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_sck <= 3'h0;
			s_ss <= 3'h7;
			s_mo <= 3'h0;
			f_sck <= 1'b0;
			f_ss <= 1'b1;
			f_mo <= 1'b0;
			f_sck_d <= 1'b0;
		end else begin
			s_sck <= {s_sck[1:0], serial_clock_pin_i};
			s_ss <= {s_ss[1:0], slave_select_n_i};
			s_mo <= {s_mo[1:0], mosi_i};
			if (s_sck[1] == s_sck[2]) f_sck <= s_sck[2];
			if (s_ss[1] == s_ss[2]) f_ss <= s_ss[2];
			if (s_mo[1] == s_mo[2]) f_mo <= s_mo[2];
			f_sck_d <= f_sck;
		end
	end
	logic s_edge, s_lead, s_push;
	assign s_edge = (f_sck != f_sck_d) && !f_ss && !master_select_i && enabled;
	assign s_lead = (f_sck != clock_polarity_i[0]);
	assign slv_load = !master_select_i && enabled && f_ss && !s_ss[2] && s_ss[1] == s_ss[2];
	assign s_push = s_edge && (s_lead == clock_phase_inverted_i[0])
		&& (s_bits == nbits_of[0] - 5'h01);

	// Slave uses select zero settings; a sample on the last bit pushes a word
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_bits <= 5'h00;
			s_sh <= 16'h0000;
			miso_o <= 1'b0;
		end else if (soft_reset_i || slv_load) begin
			s_bits <= 5'h00;
			s_sh <= hold_word[15:0] << (5'h10 - nbits_of[0]);
			miso_o <= hold_word[5'(nbits_of[0] - 5'h01)];
		end else if (s_edge) begin
			if (s_lead == clock_phase_inverted_i[0]) begin
				s_sh <= {s_sh[14:0], f_mo};
				s_bits <= s_push ? 5'h00 : s_bits + 5'h01;
			end else miso_o <= s_sh[15];
		end
	end
	assign miso_oe_o = !master_select_i && enabled && !f_ss;

	// ************************************************************
	// Two-entry receive buffer
	// ************************************************************
	// Master waits for room before starting, so a stalled reader loses no master word
	smsq_word_t rx_mem [2];
	logic rx_rd, rx_wr;
	assign push = done || s_push;
	// Extra pulses after the last bit sample nothing, so the word is not shifted again
	assign push_data = done ? (samp_edge ? {sh[14:0], miso_i} : sh) : {s_sh[14:0], f_mo};
	assign rx_wr = push && (rx_cnt < 2'(`SMSQ_RX_DEPTH));
	assign rx_rd = rx_valid_o && rx_ready_i;
	assign rx_valid_o = (rx_cnt != 2'h0);
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) rx_cnt <= 2'h0;
		else if (soft_reset_i) rx_cnt <= 2'h0;
		else rx_cnt <= rx_cnt + {1'b0, rx_wr} - {1'b0, rx_rd};
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_mem[0] <= 16'h0000;
			rx_mem[1] <= 16'h0000;
		end else begin
			if (rx_rd) rx_mem[0] <= rx_mem[1];
			if (rx_wr) rx_mem[(rx_rd ? rx_cnt - 2'h1 : rx_cnt) == 2'h0 ? 0 : 1] <= push_data;
		end
	end
	assign rx_data_o = rx_mem[0];

	// ************************************************************
	// Checks
	// ************************************************************
	logic [5:0] tgl;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) tgl <= 6'h00;
		else if (start) tgl <= 6'h00;
		else if (state == SMSQ_SHIFT && tick) tgl <= tgl + 6'h01;
	end
	// R1 slot flag
	stuck_ready_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R1
		start && r1_hit |=> !tx_ready_o [*2]) else $error("slot flag rose on stuck load");
	// R2 marker release
	marker_rel_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R2
		fixed_mode_i && dma_feed_i && cs_active && drained && marker_last && !start
		&& !soft_reset_i |=> cs_n_o == 4'hF) else $error("select held after marker");
	// R3 idle clock
	idle_clock_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R3
		state == SMSQ_IDLE && !start |=> sck == $past(clock_polarity_i[sel]))
		else $error("idle clock not at polarity");
	// R5 DMA size
	dma_size_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R5
		fixed_mode_i |=> dma_halfword_o == ($past(word_bits_i[3:0]) != 4'h0))
		else $error("size not from select zero");
	// R7 odd extra pulse
	odd_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R7
		done && div_cur == `SMSQ_FAST_DIV && nbits[0] |=> tgl == {nbits, 1'b0} + 6'h02)
		else $error("missing extra pulse");
	// R8 even clean clock
	even_clean_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R8
		done && div_cur == `SMSQ_FAST_DIV && !nbits[0] && !(cpol && !clock_phase_inverted)
		|=> tgl == {nbits, 1'b0}) else $error("extra pulse on even length");
	// R11 mixed extra pulse
	mixed_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R11
		start && fast_map[sel] && !last_fast && !(&fast_map) && clock_polarity_i[sel]
		&& !clock_phase_inverted_i[sel] |=> etotal == {nbits, 1'b0} + 6'h02)
		else $error("missing mixed pulse");
	// R12 all fast
	all_fast_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R12
		start && (&fast_map) && !nbits_of[sel][0] |=> etotal == {nbits, 1'b0})
		else $error("pulse with all fast selects");
	// R9 slave keeps running
	slave_on_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // R9
		!master_select_i && enabled && !soft_reset_i |=> enabled_o)
		else $error("slave disabled");
endmodule : smsq_core

/* File: core/smsq_defs.svh */
// Constants of the serial peripheral controller with its documented quirks
// Function
// R1: Hold plus divider 1, same slave after gap: slot flag stays low, word resent.
// R2: Fixed mode, hold, DMA: marker one releases select once transmitter drains.
// R3: In master mode the serial clock may toggle before the first transfer.
// R4: Software sets master select before programming per-select configuration.
// R5: Fixed mode DMA size follows select zero word length, whatever select.
// R6: For byte DMA on other selects, software sets select zero length to 8.
// R7: Divider 1 with odd word length emits one extra serial clock pulse.
// R8: Divider 1 with even word length gives a correct serial clock.
// R9: In slave operation the disable command is ignored until software reset.
// R10: Software reads the received word, then resets, to stop slave operation.
// R11: Polarity 1, phase 0, slow then fast select gives an extra pulse.
// R12: When every select uses divider 1, no extra pulse appears; the code still adds the R7 pulse for odd word lengths.
// R13: Software avoids select hold together with divider 1.
// R14: Software drives a held select as general output when DMA feeds.
// R15: Word length selects 8 to 16 bits; above 8 reports halfword.
`ifndef SMSQ_DEFS_SVH
`define SMSQ_DEFS_SVH
`define SMSQ_NUM_CS 4
`define SMSQ_DIV_W 8
`define SMSQ_BITS_W 4
`define SMSQ_WORD_W 16
`define SMSQ_TX_W 25
`define SMSQ_MARKER_BIT 24
`define SMSQ_PCS_LSB 16
`define SMSQ_BASE_BITS 5'h08
`define SMSQ_FAST_DIV 8'h01
`define SMSQ_RX_DEPTH 2
`endif

/* File: core/smsq_pkg.sv */
// Types of the serial peripheral controller
package smsq_pkg;
	typedef enum logic [0:0] {
		SMSQ_IDLE = 1'b0,
		SMSQ_SHIFT = 1'b1
	} smsq_state_e;
	typedef logic [15:0] smsq_word_t;
endpackage : smsq_pkg

/* File: test/smsq_slave_model.sv */
// Behavioural serial slave: answers all ones, counts clock edges, captures the data line
`timescale 1ns/10ps
module smsq_slave_model (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic sck_i,
	input wire logic [3:0] cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic [15:0] toggles_o,
	output logic [15:0] mosi_word_o
);
	logic sck_q;
	logic sel_q;
	logic pat;
	logic sel;
	logic odd;
	// Released line shows a changing pattern, so a stale bit is never read as data
	assign sel = (cs_n_i != 4'hF);
	assign miso_o = sel ? 1'b1 : pat;
	// Edges just after release still count, so a late extra pulse is seen
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sck_q <= 1'b0;
			sel_q <= 1'b0;
			pat <= 1'b0;
			toggles_o <= 16'h0000;
			odd <= 1'b0;
			mosi_word_o <= 16'h0000;
		end else begin
			sck_q <= sck_i;
			sel_q <= sel;
			pat <= ~pat;
			if (sck_i !== sck_q && (sel || sel_q)) begin
				toggles_o <= toggles_o + 16'h0001;
				odd <= ~odd;
				// Second edge of each pair samples, as for phase zero
				if (odd) mosi_word_o <= {mosi_word_o[14:0], mosi_i};
			end else if (!sel && !sel_q) odd <= 1'b0;
		end
	end
endmodule : smsq_slave_model

/* File: test/tb.sv */
// Self-checking bench for the serial peripheral controller
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0, rst_n = 1'b0, mst = 1'b0, en = 1'b0, dis = 1'b0, srst = 1'b0;
	logic fixed = 1'b1, dma = 1'b0, txv = 1'b0, rxr = 1'b0, miso, txr, drained;
	logic enabled, halfw, rxv, sck, sck_oe, mosi, mosi_oe, miso_o, miso_oe;
	logic [1:0] csi = 2'h0;
	logic [31:0] div = 32'h0000_0000;
	logic [15:0] bits = 16'h0000, rxd, tog;
	logic [3:0] hold = 4'h0, pol = 4'h0, pha = 4'h0, cs_n;
	logic [24:0] txd = 25'h0000000;
	logic ss_n = 1'b1, s_clk = 1'b0, s_mosi = 1'b0;
	logic [15:0] mw;
	int n_fail = 0, tests_run = 0;
	always #4 clk = ~clk;
	smsq_core i_dut (.ref_clk_i(clk), .arst_n_i(rst_n), .master_select_i(mst),
		.enable_i(en), .disable_i(dis), .soft_reset_i(srst), .fixed_mode_i(fixed),
		.dma_feed_i(dma), .cs_index_i(csi), .serial_clock_divider_i(div),
		.word_bits_i(bits), .cs_hold_after_transfer_i(hold), .clock_polarity_i(pol),
		.clock_phase_inverted_i(pha), .tx_valid_i(txv), .tx_data_i(txd),
		.tx_ready_o(txr), .transmit_drained_o(drained), .enabled_o(enabled),
		.dma_halfword_o(halfw), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rxr),
		.serial_clock_pin_o(sck), .serial_clock_pin_oe_o(sck_oe),
		.serial_clock_pin_i(s_clk), .mosi_o(mosi), .mosi_oe_o(mosi_oe), .mosi_i(s_mosi),
		.miso_o(miso_o), .miso_oe_o(miso_oe), .miso_i(miso), .cs_n_o(cs_n),
		.slave_select_n_i(ss_n));
	smsq_slave_model i_slave (.ref_clk_i(clk), .arst_n_i(rst_n), .sck_i(sck),
		.cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .toggles_o(tog), .mosi_word_o(mw));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_of_test;
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// One-cycle command pulse; inputs move 1 ns after the edge
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	// Word held until the edge where ready is seen high
	task automatic send(input logic [24:0] w);
		txd = w;
		txv = 1'b1;
		while (txr !== 1'b1) tick(1);
		tick(1);
		txv = 0;
	endtask : send
	// Bounded wait for a received word, then it is checked and taken
	task automatic take(input logic [15:0] exp);
		int k;
		k = 0;
		while (rxv !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		// A wait that runs out counts, so stale buffer data cannot pass
		chk({15'h0, rxv}, 16'h0001);
		chk(rxd, exp);
		rxr = 1'b1;
		tick(1);
		rxr = 1'b0;
	endtask : take
	task automatic xfer(input logic [1:0] cs, input logic [15:0] etog, input logic [15:0] erx);
		logic [15:0] t0;
		csi = cs;
		t0 = tog;
		send(25'h00000A5);
		take(erx);
		tick(4);
		chk(tog - t0, etog);
	endtask : xfer
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_lengths;
		for (int v = 0; v <= 8; v++) begin
			bits = 16'(v);
			div = 32'h0000_0001;
			// odd lengths at divider 1 carry two extra edges
			xfer(2'h0, 16'(2 * (8 + v) + ((v % 2) * 2)), 16'((1 << (8 + v)) - 1));
		end
		div = 32'h0000_0002;
		bits = 16'h0001;
		xfer(2'h0, 16'h0012, 16'h01FF);
		chk(mw & 16'h01FF, 16'h00A5);
	endtask : t_lengths
	task automatic t_mixed;
		bits = 16'h0000;
		pol = 4'hF;
		pha = 4'h0;
		div = 32'h0000_0102;
		xfer(2'h0, 16'h0010, 16'h00FF);
		xfer(2'h1, 16'h0012, 16'h00FF);
		div = 32'h0101_0101;
		xfer(2'h0, 16'h0010, 16'h00FF);
		xfer(2'h1, 16'h0010, 16'h00FF);
		chk(mw & 16'h00FF, 16'h00A5);
		pol = 4'h0;
	endtask : t_mixed
	task automatic t_size;
		csi = 2'h1;
		bits = 16'h0002;
		tick(2);
		chk({15'h0, halfw}, 16'h0001);
		bits = 16'h0020;
		tick(2);
		chk({15'h0, halfw}, 16'h0000);
		bits = 16'h0000;
		tick(2);
		chk({15'h0, halfw}, 16'h0000);
		// Variable mode takes the select from the word itself
		fixed = 1'b0;
		bits = 16'h0020;
		send(25'h00100A5);
		take(16'h03FF);
		chk({15'h0, halfw}, 16'h0001);
		fixed = 1'b1;
		bits = 16'h0000;
	endtask : t_size
	// Hold kept off divider 1, as software must
	task automatic t_hold;
		div = 32'h0000_0002;
		dma = 1'b1;
		hold = 4'h1;
		xfer(2'h0, 16'h0010, 16'h00FF);
		// a held select under DMA belongs on a general output; the release is shown here
		chk({12'h0, cs_n}, 16'h000E);
		csi = 2'h0;
		send(25'h10000A5);
		take(16'h00FF);
		while (drained !== 1'b1) tick(1);
		tick(1);
		chk({12'h0, cs_n}, 16'h000F);
		hold = 4'h0;
		dma = 1'b0;
	endtask : t_hold
	// Held select at divider 1 on one slave: the second word goes out twice
	task automatic t_stuck;
		logic [15:0] t0;
		div = 32'h0000_0001;
		hold = 4'h1;
		xfer(2'h0, 16'h0010, 16'h00FF);
		t0 = tog;
		send(25'h00000A5);
		tick(1);
		chk({15'h0, txr}, 16'h0000);
		take(16'h00FF);
		take(16'h00FF);
		tick(4);
		chk(tog - t0, 16'h0020);
		hold = 4'h0;
	endtask : t_stuck
	task automatic t_slave;
		logic [7:0] b;
		b = 8'h96;
		mst = 1'b0;
		pulse(srst);
		pulse(en);
		pulse(dis);
		tick(2);
		chk({15'h0, enabled}, 16'h0001);
		// Pins pass three stages, so every level is held several cycles
		ss_n = 1'b0;
		tick(5);
		chk({13'h0, sck_oe, mosi_oe, miso_oe}, 16'h0001);
		for (int i = 7; i >= 0; i--) begin
			s_mosi = b[i];
			tick(4);
			s_clk = 1'b1;
			tick(4);
			s_clk = 1'b0;
			tick(4);
		end
		take(16'h0096);
		ss_n = 1'b1;
		// Received word read first, then the reset stops slave operation
		pulse(srst);
		tick(1);
		chk({15'h0, enabled}, 16'h0000);
	endtask : t_slave
	// Main sequence
	initial begin
		tick(8);
		rst_n = 1'b1;
		chk({cs_n, 11'h0, txr}, 16'hF001);
		// Master chosen before any per-select setting
		mst = 1'b1;
		pulse(en);
		chk({13'h0, sck_oe, mosi_oe, miso_oe}, 16'h0006);
		t_lengths();
		t_mixed();
		t_size();
		t_hold();
		t_stuck();
		t_slave();
		end_of_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		#400000;
		n_fail++;
		end_of_test();
	end
endmodule : tb
